// ==== bbsp_host.sv ====
/*
 * bbsp_host: host controller that runs read and write cycles on a
 * battery-backed 8K x 8 asynchronous static RAM through its pins.
 * assumes the memory pins are sampled synchronously to sys_clk_i and that
 * the power_good_i level comes from a supply monitor.
 */
`timescale 1ns/1ps
module bbsp_host (
	input  wire logic                          sys_clk_i,
	input  wire logic                          rstn_i,
	// user side
	input  wire logic                          req_valid_i,
	input  wire logic                          req_write_i,
	input  wire logic [bbsp_pkg::ADDR_W-1:0]   req_addr_i,
	input  wire logic [bbsp_pkg::DATA_W-1:0]   req_wdata_i,
	output logic                               req_ready_o,
	output logic                               rsp_valid_o,
	output logic [bbsp_pkg::DATA_W-1:0]        rsp_rdata_o,
	input  wire logic                          power_good_i,
	output logic                               power_warn_o,
	output logic                               ready_o,
	// memory side
	output logic [bbsp_pkg::ADDR_W-1:0]        mem_addr_o,
	output logic                               select_active_low_n_o,
	output logic                               select_active_high_o,
	output logic                               out_enable_n_o,
	output logic                               write_n_o,
	input  wire logic [bbsp_pkg::DATA_W-1:0]   mem_dq_i,
	output logic [bbsp_pkg::DATA_W-1:0]        mem_dq_o,
	output logic                               mem_dq_oe_n_o,
	input  wire logic                          power_fail_warn_n_i
);
	bbsp_pkg::bbsp_state_t             state_q;
	bbsp_pkg::bbsp_state_t             state_d;
	logic [bbsp_pkg::ADDR_W-1:0]       addr_q;
	logic [bbsp_pkg::ADDR_W-1:0]       addr_d;
	logic [bbsp_pkg::DATA_W-1:0]       wdata_q;
	logic [bbsp_pkg::DATA_W-1:0]       wdata_d;
	logic [bbsp_pkg::DATA_W-1:0]       rdata_q;
	logic [bbsp_pkg::DATA_W-1:0]       rdata_d;
	logic                              rsp_q;
	logic                              rsp_d;
	logic                              sel_q;
	logic                              sel_d;
	logic                              oe_q;
	logic                              oe_d;
	logic                              we_q;
	logic                              we_d;
	logic                              drive_q;
	logic                              drive_d;
	logic                              warn_q;
	logic                              warn_d;
	logic                              tmr_load;
	logic [15:0]                       tmr_count;
	logic                              tmr_done;

	bbsp_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.load_i    (tmr_load),
		.count_i   (tmr_count),
		.done_o    (tmr_done)
	);

	// new requests are refused while the memory warns of power fail or is down
	assign req_ready_o = (state_q == bbsp_pkg::BBSP_IDLE) && power_good_i && warn_q == 1'b0;
	assign ready_o     = (state_q != bbsp_pkg::BBSP_LOCKOUT);

	always_comb begin
		state_d   = state_q;
		addr_d    = addr_q;
		wdata_d   = wdata_q;
		rdata_d   = rdata_q;
		rsp_d     = 1'b0;
		sel_d     = sel_q;
		oe_d      = oe_q;
		we_d      = we_q;
		drive_d   = drive_q;
		warn_d    = !power_fail_warn_n_i;
		tmr_load  = 1'b0;
		tmr_count = 16'h0000;
		case (state_q)
			bbsp_pkg::BBSP_LOCKOUT: begin
				sel_d   = 1'b0;
				we_d    = 1'b0;
				oe_d    = 1'b0;
				drive_d = 1'b0;
				if (!power_good_i) begin
					tmr_load  = 1'b1;
					tmr_count = 16'(bbsp_pkg::LOCKOUT_CYC);
				end else if (tmr_done) begin
					state_d = bbsp_pkg::BBSP_IDLE;
				end
			end
			bbsp_pkg::BBSP_IDLE: begin
				if (!power_good_i) begin
					state_d   = bbsp_pkg::BBSP_LOCKOUT;
					tmr_load  = 1'b1;
					tmr_count = 16'(bbsp_pkg::LOCKOUT_CYC);
				end else if (req_valid_i && req_ready_o) begin
					addr_d    = req_addr_i;
					wdata_d   = req_wdata_i;
					sel_d     = 1'b1;
					tmr_load  = 1'b1;
					if (req_write_i) begin
						we_d      = 1'b1;
						drive_d   = 1'b1;
						state_d   = bbsp_pkg::BBSP_WRITE;
						tmr_count = 16'(bbsp_pkg::WPULSE_CYC);
					end else begin
						oe_d      = 1'b1;
						state_d   = bbsp_pkg::BBSP_READ;
						tmr_count = 16'(bbsp_pkg::ACCESS_CYC);
					end
				end
			end
			bbsp_pkg::BBSP_READ: begin
				if (tmr_done) begin
					rdata_d   = mem_dq_i;
					rsp_d     = 1'b1;
					sel_d     = 1'b0;
					oe_d      = 1'b0;
					state_d   = bbsp_pkg::BBSP_RECOVER;
					tmr_load  = 1'b1;
					// let the memory float its drivers
					tmr_count = 16'(bbsp_pkg::TURN_CYC);
				end
			end
			bbsp_pkg::BBSP_WRITE: begin
				if (tmr_done) begin
					we_d      = 1'b0;
					state_d   = bbsp_pkg::BBSP_HOLD;
					tmr_load  = 1'b1;
					tmr_count = 16'(bbsp_pkg::HOLD_CYC);
				end
			end
			bbsp_pkg::BBSP_HOLD: begin
				// address and data held past the end
				if (tmr_done) begin
					sel_d     = 1'b0;
					drive_d   = 1'b0;
					rsp_d     = 1'b1;
					state_d   = bbsp_pkg::BBSP_RECOVER;
					tmr_load  = 1'b1;
					tmr_count = 16'(bbsp_pkg::RECOVERY_CYC);
				end
			end
			bbsp_pkg::BBSP_RECOVER: begin
				if (tmr_done) begin
					state_d = bbsp_pkg::BBSP_IDLE;
				end
			end
			default: begin
				state_d = bbsp_pkg::BBSP_LOCKOUT;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state_q <= bbsp_pkg::BBSP_LOCKOUT;
			addr_q  <= 13'h0000;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			rsp_q   <= 1'b0;
			sel_q   <= 1'b0;
			oe_q    <= 1'b0;
			we_q    <= 1'b0;
			drive_q <= 1'b0;
			warn_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			rsp_q   <= rsp_d;
			sel_q   <= sel_d;
			oe_q    <= oe_d;
			we_q    <= we_d;
			drive_q <= drive_d;
			warn_q  <= warn_d;
		end
	end

	// host drives data only in write, output enable never low then
	assign mem_addr_o            = addr_q;
	assign select_active_low_n_o = !sel_q;
	assign select_active_high_o  = sel_q;
	assign out_enable_n_o        = !oe_q;
	assign write_n_o             = !we_q;
	assign mem_dq_o              = wdata_q;
	assign mem_dq_oe_n_o         = !drive_q;
	assign rsp_valid_o           = rsp_q;
	assign rsp_rdata_o           = rdata_q;
	assign power_warn_o          = warn_q;
endmodule

// ==== bbsp_pkg.sv ====
/*
 * bbsp_pkg: constants for the host-side controller of a battery-backed
 * 8K x 8 asynchronous static RAM port.
 * assumes a 100 MHz system clock (10 ns period).
 */
package bbsp_pkg;
	localparam int          CLK_PERIOD_NS        = 10;
	localparam int          ADDR_W               = 13;
	localparam int          DATA_W               = 8;
	// access time of the slowest speed grade, ns
	localparam int          ACCESS_TIME_NS       = 250;
	localparam int          OE_ACCESS_NS         = 125;
	localparam int          WRITE_PULSE_NS       = 200;
	localparam int          DATA_SETUP_NS        = 90;
	localparam int          DATA_HOLD_NS         = 5;
	localparam int          WRITE_RECOVERY_NS    = 10;
	localparam int          OUT_HIGHZ_NS         = 125;
	localparam int          POWER_UP_LOCKOUT_US  = 120;
	localparam int          WARNING_TO_DESELECT_MIN_US = 10;
	// least times round up, with one cycle more on access
	localparam int          ACCESS_CYC    = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int          WPULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          HOLD_CYC      = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RECOVERY_CYC  = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TURN_CYC      = (OUT_HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LOCKOUT_CYC   = (POWER_UP_LOCKOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W         = 16;
	// timer value after reset: a whole power-up lockout still to run
	localparam logic [15:0] LOCKOUT_RESET = 16'(LOCKOUT_CYC);
	typedef enum logic [2:0] {
		BBSP_LOCKOUT = 3'b000,
		BBSP_IDLE    = 3'b001,
		BBSP_READ    = 3'b010,
		BBSP_WRITE   = 3'b011,
		BBSP_HOLD    = 3'b100,
		BBSP_RECOVER = 3'b101
	} bbsp_state_t;
endpackage

// ==== bbsp_timer.sv ====
/*
 * bbsp_timer: down counter that marks when a loaded cycle count has run out.
 * assumes load and count come from the controller in the same clock domain.
 */
`timescale 1ns/1ps
module bbsp_timer (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        load_i,
	input  wire logic [15:0] count_i,
	output logic             done_o
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load_i) begin
			cnt_d = count_i;
		end else if (cnt_q != 16'h0000) begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	// starts loaded with a full power-up lockout so the first lockout after reset runs in full
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cnt_q <= bbsp_pkg::LOCKOUT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// done looks only at the count: the controller's load depends on done
	assign done_o = (cnt_q == 16'h0000);
endmodule

// ==== bbsp_host_monitor.sv ====
/* bbsp_host_chk: pin-level assertions for bbsp_host.
   assumes one clock domain and is bound into every bbsp_host. */
`timescale 1ns/1ps
module bbsp_host_chk (
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic        power_good_i,
	input wire logic        ready_o,
	input wire logic        rsp_valid_o,
	input wire logic [12:0] mem_addr_o,
	input wire logic        select_active_low_n_o,
	input wire logic        out_enable_n_o,
	input wire logic        write_n_o,
	input wire logic        mem_dq_oe_n_o
);
	logic [15:0] pg_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// cycles of good supply since reset or the last dropout
	always_ff @(posedge sys_clk_i) begin
		pg_q <= (!rstn_i || !power_good_i) ? 16'h0000 : pg_q + {15'h0000, pg_q != 16'hFFFF};
	end
	property p_addr_hold;
		!select_active_low_n_o && $past(!select_active_low_n_o) |-> $stable(mem_addr_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in a cycle");
	property p_recover;
		$rose(select_active_low_n_o) |=> select_active_low_n_o;
	endproperty
	a_recover: assert property (p_recover) else $error("no recovery gap");
	property p_lockout;
		$rose(ready_o) |-> pg_q >= 16'h2EE0;
	endproperty
	a_lockout: assert property (p_lockout) else $error("lockout too short");
	property p_quiet;
		!ready_o |-> select_active_low_n_o && write_n_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("access during lockout");
	property p_no_clash;
		!mem_dq_oe_n_o |-> out_enable_n_o;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("bus contention");
	property p_read_wait;
		$fell(out_enable_n_o) |-> ##27 rsp_valid_o;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read sampled off time");
	property p_pulse;
		$fell(write_n_o) |-> ##20 (!write_n_o && !mem_dq_oe_n_o);
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse short");
	property p_data_hold;
		$rose(write_n_o) |-> !mem_dq_oe_n_o && !select_active_low_n_o;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data dropped at strobe end");
endmodule
bind bbsp_host bbsp_host_chk u_chk (.sys_clk_i, .rstn_i, .power_good_i, .ready_o, .rsp_valid_o, .mem_addr_o,
	.select_active_low_n_o, .out_enable_n_o, .write_n_o, .mem_dq_oe_n_o);

// ==== bbsp_sram_model.sv ====
/* bbsp_sram_model: behavioural 8K x 8 battery-backed memory.
   assumes pins change on sys_clk_i edges and supply_ok_i is the bench supply. */
`timescale 1ns/1ps
module bbsp_sram_model (
	input  wire logic        sys_clk_i,
	input  wire logic        supply_ok_i,
	input  wire logic [12:0] addr_i,
	input  wire logic        sel_n_i,
	input  wire logic        sel_i,
	input  wire logic        oe_n_i,
	input  wire logic        write_n_i,
	input  wire logic [7:0]  dq_i,
	output logic      [7:0]  dq_o,
	output logic             warn_n_o
);
	logic [7:0] mem [8192];
	logic [7:0] last_q = 8'h00;
	logic [9:0] fail_q = 10'h000;
	logic [4:0] acc_q = 5'h00;
	logic       dead, on, rd, wr;
	assign warn_n_o = supply_ok_i;
	assign dead = fail_q == 10'h3E8;
	assign on = !sel_n_i && sel_i && !dead;
	assign wr = on && !write_n_i;
	assign rd = on && write_n_i && !oe_n_i;
	assign dq_o = (rd && acc_q >= 5'h19) ? mem[addr_i] : ~last_q;
	always @(posedge sys_clk_i) begin
		fail_q <= supply_ok_i ? 10'h000 : fail_q + {9'h000, !dead};
		acc_q <= rd ? acc_q + {4'h0, acc_q != 5'h1F} : 5'h00;
		last_q <= dq_o;
	end
	always @(negedge wr) begin
		mem[addr_i] <= dq_i;
	end
endmodule

// ==== test_battery_backed_sram_port.sv ====
/* test_battery_backed_sram_port: self-checking bench for bbsp_host.
   assumes the memory model and monitor are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_battery_backed_sram_port;
	logic        sys_clk_i = 1'b0, rstn_i = 1'b0, pgood = 1'b1, vld = 1'b0, wen = 1'b0;
	logic [12:0] addr = 13'h0000, maddr;
	logic [7:0]  wdat = 8'h00, rdata, from_mem, to_mem, bus;
	logic        rdy_req, rsp, warn, rdy, sl_n, sh, oe_n, w_n, dq_oe_n, warn_n;
	int          err_total = 0, compares = 0;
	assign bus = dq_oe_n ? from_mem : to_mem;
	bbsp_host DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(vld), .req_write_i(wen),
		.req_addr_i(addr), .req_wdata_i(wdat), .req_ready_o(rdy_req), .rsp_valid_o(rsp), .rsp_rdata_o(rdata),
		.power_good_i(pgood), .power_warn_o(warn), .ready_o(rdy), .mem_addr_o(maddr),
		.select_active_low_n_o(sl_n), .select_active_high_o(sh), .out_enable_n_o(oe_n), .write_n_o(w_n),
		.mem_dq_i(bus), .mem_dq_o(to_mem), .mem_dq_oe_n_o(dq_oe_n), .power_fail_warn_n_i(warn_n));
	bbsp_sram_model u_mem (.sys_clk_i(sys_clk_i), .supply_ok_i(pgood), .addr_i(maddr), .sel_n_i(sl_n),
		.sel_i(sh), .oe_n_i(oe_n), .write_n_i(w_n), .dq_i(bus), .dq_o(from_mem), .warn_n_o(warn_n));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge sys_clk_i);
		vld = 1'b1;
		wen = w;
		addr = a;
		wdat = d;
		// ready is judged off the edge, so the request is taken at the next rising edge
		while (rdy_req !== 1'b1 && n < 200) begin
			@(negedge sys_clk_i);
			n++;
		end
		@(negedge sys_clk_i);
		vld = 1'b0;
		while (rsp !== 1'b1 && n < 400) begin
			@(negedge sys_clk_i);
			n++;
		end
		`CHK(n < 400, 1'b1)
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 13000) begin
			@(negedge sys_clk_i);
			n++;
		end
	endtask
	task automatic t_lockout;
		repeat (11900) @(negedge sys_clk_i);
		`CHK(rdy_req, 1'b0)
		wait_rdy();
		`CHK(rdy, 1'b1)
	endtask
	task automatic t_rw;
		op(1'b1, 13'h0000, 8'hA5);
		for (int i = 0; i < 13; i++) op(1'b1, 13'h0001 << i, 8'h40 + 8'(i));
		for (int i = 0; i < 13; i++) begin
			op(1'b0, 13'h0001 << i, 8'h00);
			`CHK(rdata, 8'h40 + 8'(i))
		end
		op(1'b0, 13'h0000, 8'h00);
		`CHK(rdata, 8'hA5)
	endtask
	task automatic t_power;
		@(negedge sys_clk_i);
		pgood = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		`CHK(warn, 1'b1)
		`CHK(rdy_req, 1'b0)
		repeat (1100) @(negedge sys_clk_i);
		pgood = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		`CHK(warn, 1'b0)
		`CHK(rdy, 1'b0)
		wait_rdy();
		op(1'b0, 13'h1000, 8'h00);
		`CHK(rdata, 8'h4C)
	endtask
	task automatic print_verdict;
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		t_lockout();
		t_rw();
		t_power();
		print_verdict();
	end
	initial begin
		#600us;
		err_total++;
		print_verdict();
	end
endmodule
